/* core/hb_csr_port.sv */
// Multiplexed register port with four channel banks, a common bank and reset control.
`timescale 1ns/1ns
`default_nettype none
module hb_csr_port (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_hard_rst_n,
  input wire logic [hb_pkg::DATA_W-1:0] i_cs_ad,
  input wire logic i_cs_strobe,
  input wire logic i_cs_rw,
  input wire logic i_err_event,
  output logic [hb_pkg::DATA_W-1:0] o_cs_ad_out,
  output logic o_cs_ad_oe,
  output logic o_pll_rst,
  output logic o_fifo_rst,
  output logic o_soft_rst,
  output logic o_err_latched
);
  import hb_pkg::*;

  typedef struct packed {
    hb_state_t state;
    logic [5:0] ctl;
    logic [4:0] start;
    logic [4:0] stop;
    logic [4:0] addr;
    logic hold;
    logic phase;
    logic we;
    logic [4:0] wa;
    logic [15:0] wd;
    logic rd;
    logic [4:0] ra;
    logic v1;
    logic stat_hit;
    logic [15:0] dout;
    logic oe;
    logic err;
    logic soft_p;
    logic err_p;
    logic [15:0] ad_q;
    logic strb_q;
    logic rw_q;
  } hb_port_st_t;

  hb_port_st_t st;
  hb_port_st_t next_st;
  logic [SYNC_DEPTH-1:0] hr_sync;
  logic hard_rst;
  logic rst_all;
  logic burst;
  logic [4:0] step_addr;
  logic [15:0] rd_or;
  logic [15:0] status_word;
  logic [15:0] rd_vec [N_BANKS];

  // ***************************************************************
  // Hard reset pin
  // ***************************************************************

  // The pin clears the chain at once; release walks through three flops so
  // that a release near the clock edge cannot split the design.
  always_ff @(posedge i_ref_clk or negedge i_hard_rst_n) begin
    if (!i_hard_rst_n) begin
      hr_sync <= '0;
    end else begin
      hr_sync <= {hr_sync[SYNC_DEPTH-2:0], 1'b1};
    end
  end

  assign hard_rst = !(hr_sync[1] && hr_sync[2]);
  assign rst_all = i_rst || hard_rst;

  // ***************************************************************
  // Bus sequencer
  // ***************************************************************

  assign burst = st.ctl[BURST_BIT-CTL_LSB];
  // Bursts wrap from the stop address back to the start address.
  assign step_addr = (st.addr == st.stop) ? st.start : st.addr + 5'h01;
  assign status_word = {15'h0000, st.err};

  always_comb begin
    next_st = st;
    // Bus pins are synchronous to the master clock: one register stage.
    next_st.ad_q = i_cs_ad;
    next_st.strb_q = i_cs_strobe;
    next_st.rw_q = i_cs_rw;
    next_st.we = 1'b0;
    next_st.rd = 1'b0;
    next_st.soft_p = 1'b0;
    next_st.err_p = 1'b0;
    next_st.v1 = st.rd;
    next_st.stat_hit = st.rd && st.ctl[COMMON_BANK] && (st.ra == REG_STATUS);
    next_st.dout = st.v1 ? (rd_or | (st.stat_hit ? status_word : 16'h0000)) : 16'h0000;
    next_st.oe = st.v1;
    // A new error in the clearing cycle is kept.
    next_st.err = i_err_event || (st.err && !st.err_p);
    case (st.state)
      HB_IDLE: begin
        if (st.strb_q) begin
          next_st.ctl = st.ad_q[15:CTL_LSB];
          next_st.stop = st.ad_q[STOP_LSB+4:STOP_LSB];
          next_st.start = st.ad_q[START_LSB+4:START_LSB];
          next_st.addr = st.ad_q[START_LSB+4:START_LSB];
          next_st.state = st.rw_q ? HB_RTURN : HB_WDATA;
        end
      end
      HB_WDATA: begin
        next_st.we = 1'b1;
        next_st.wa = st.addr;
        next_st.wd = st.ad_q;
        if (st.ctl[COMMON_BANK] && (st.addr == REG_RESET_CTL)) begin
          // Reset bits act as pulses and are never stored.
          next_st.wd = st.ad_q & ~RC_PULSE_MASK;
          next_st.soft_p = st.ad_q[SOFT_RST_BIT];
          next_st.err_p = st.ad_q[ERR_RST_BIT];
        end
        if (burst && st.strb_q) begin
          next_st.addr = step_addr;
        end else begin
          next_st.state = HB_IDLE;
        end
      end
      HB_RTURN: begin
        // Read select still high after the address selects extended data hold.
        next_st.hold = st.rw_q;
        next_st.phase = 1'b0;
        next_st.state = HB_RISS;
      end
      HB_RISS: begin
        next_st.rd = 1'b1;
        next_st.ra = st.addr;
        if (st.hold) begin
          next_st.phase = !st.phase;
        end
        if (burst && (!st.hold || st.phase)) begin
          next_st.addr = step_addr;
        end
        if ((!burst || !st.strb_q) && (!st.hold || st.phase)) begin
          next_st.state = HB_IDLE;
        end
      end
      default: begin
        next_st.state = HB_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (rst_all) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ***************************************************************
  // Register banks
  // ***************************************************************

  hb_bank_if bif[N_BANKS] ();

  for (genvar g = 0; g < N_BANKS; g++) begin : g_bank
    // Bank g follows control bit g, so channel banks 0-3 and common bank 4.
    assign bif[g].sel = st.ctl[g];
    // The status word is read-only, so the bank never stores that address.
    assign bif[g].we = st.we && (st.wa != REG_STATUS);
    assign bif[g].rd = st.rd;
    assign bif[g].srst = rst_all || st.soft_p;
    assign bif[g].addr = st.we ? st.wa : st.ra;
    assign bif[g].wdata = st.wd;
    assign rd_vec[g] = bif[g].rdata;
    hb_bank #(
      .LO((g == COMMON_BANK) ? CM_LO : CH_LO),
      .HI((g == COMMON_BANK) ? CM_HI : CH_HI)
    ) u_bank (
      .i_ref_clk(i_ref_clk),
      .bus(bif[g])
    );
  end

  always_comb begin
    rd_or = 16'h0000;
    for (int i = 0; i < N_BANKS; i++) begin
      rd_or = rd_or | rd_vec[i];
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************

  assign o_cs_ad_out = st.dout;
  assign o_cs_ad_oe = st.oe;
  // The PLL only restarts on a hard reset; soft reset leaves it running.
  assign o_pll_rst = hard_rst;
  assign o_fifo_rst = hard_rst || st.err_p;
  assign o_soft_rst = st.soft_p;
  assign o_err_latched = st.err;

  // ***************************************************************
  // Checks
  // ***************************************************************

  chk_write_pulse: assert property (
    @(posedge i_ref_clk) disable iff (rst_all)
    (st.state == HB_WDATA) |=> (st.we && (st.wa == $past(st.addr))))
    else $error("Data cycle did not produce a write.");

  chk_single_ends: assert property (
    @(posedge i_ref_clk) disable iff (rst_all)
    (st.state == HB_WDATA && !burst) |=> (st.state == HB_IDLE))
    else $error("Single write did not return to idle.");

  chk_read_data_out: assert property (
    @(posedge i_ref_clk) disable iff (rst_all)
    (st.state == HB_RTURN) |-> ##2 (st.rd && !o_cs_ad_oe) ##2 o_cs_ad_oe)
    else $error("Read data not driven two cycles after issue.");

  chk_burst_wrap: assert property (
    @(posedge i_ref_clk) disable iff (rst_all)
    (st.state == HB_WDATA && burst && st.strb_q && st.addr == st.stop)
    |=> (st.addr == $past(st.start)))
    else $error("Burst did not wrap to the start address.");

  chk_burst_step: assert property (
    @(posedge i_ref_clk) disable iff (rst_all)
    (st.state == HB_WDATA && burst && st.strb_q && st.addr != st.stop)
    |=> (st.addr == $past(st.addr) + 5'h01) && (st.state == HB_WDATA))
    else $error("Burst write did not step the address.");

  chk_soft_oneshot: assert property (
    @(posedge i_ref_clk) disable iff (rst_all)
    o_soft_rst |=> !o_soft_rst)
    else $error("Soft reset pulse lasted more than one cycle.");

  chk_err_clear: assert property (
    @(posedge i_ref_clk) disable iff (rst_all)
    (st.err_p && !i_err_event) |=> !o_err_latched)
    else $error("Error reset did not clear the latched error.");

  chk_err_set_wins: assert property (
    @(posedge i_ref_clk) disable iff (rst_all)
    i_err_event |=> o_err_latched)
    else $error("New error was lost.");

  chk_reset_bits_store: assert property (
    @(posedge i_ref_clk) disable iff (rst_all)
    (st.we && st.ctl[COMMON_BANK] && st.wa == REG_RESET_CTL) |-> ((st.wd & RC_PULSE_MASK) == 16'h0000))
    else $error("Reset control pulse bits were stored.");

  chk_oe_length: assert property (
    @(posedge i_ref_clk) disable iff (rst_all)
    (st.state == HB_RTURN && !burst && !st.rw_q) |-> ##4 o_cs_ad_oe ##1 !o_cs_ad_oe)
    else $error("Single read drove the bus for other than one cycle.");
endmodule
`default_nettype wire

/* core/hb_pkg.sv */
// Package with constants and types for the register port and its reset sequencing.
// Notes on behaviour
// - One 16-bit bus carries address and data, sampled on the master clock.
// - Each transaction is one address cycle followed by one or more data cycles.
// - Bus lines and the read/write select decide the type and the data cycle count.
// - Address word holds start address, stop address and a 6-bit control field.
// - The control field steers address and data to one or several banks.
// - Five banks, four channels and one common, each with 5-bit addressing.
// - Channel banks are identical, so one write updates every enabled channel.
// - Common bank addresses do not overlap the channel bank addresses.
// - A read of several banks returns the bitwise OR of their values.
// - Bursts read or write a sequential block after one address cycle.
// - Without burst, one access at the start address; stop address ignored.
// - Writing bit 0 of reset_control soft resets registers, not PLL or FIFOs.
// - Writing bit 3 of reset_control clears latched errors and resets FIFOs.
// - Hard reset asserts asynchronously; release is synchronous to the master clock.
// - Bit 15 burst, bit 14 common, bits 13 to 10 channels 3 to 0.
// - Burst stop is bits 9 to 5, start bits 4 to 0, stepped inclusive.
package hb_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam int N_BANKS = 5;
  localparam int COMMON_BANK = 4;
  // Address word layout.
  localparam int BURST_BIT = 15;
  localparam int CTL_LSB = 10;
  localparam int STOP_LSB = 5;
  localparam int START_LSB = 0;
  // Bank address ranges.
  localparam logic [4:0] CH_LO = 5'h00;
  localparam logic [4:0] CH_HI = 5'h17;
  localparam logic [4:0] CM_LO = 5'h18;
  localparam logic [4:0] CM_HI = 5'h1f;
  // Common registers.
  localparam logic [4:0] REG_RESET_CTL = 5'h19;
  localparam logic [4:0] REG_STATUS = 5'h1a;
  localparam int SOFT_RST_BIT = 0;
  localparam int ERR_RST_BIT = 3;
  localparam int ERR_FLAG_BIT = 0;
  localparam logic [15:0] RC_PULSE_MASK = 16'h0009;
  localparam logic [15:0] REG_RESET_VAL = 16'h0000;
  // Hard reset pin synchroniser depth.
  localparam int SYNC_DEPTH = 3;

  typedef enum logic [1:0] {
    HB_IDLE = 2'b00,
    HB_WDATA = 2'b01,
    HB_RTURN = 2'b10,
    HB_RISS = 2'b11
  } hb_state_t;
endpackage

/* core/hb_bank_if.sv */
// Interface between the port controller and one register bank.
`timescale 1ns/1ns
`default_nettype none
interface hb_bank_if;
  logic sel;
  logic we;
  logic rd;
  logic srst;
  logic [4:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport ctrl (output sel, output we, output rd, output srst, output addr, output wdata,
    input rdata);
  modport bank (input sel, input we, input rd, input srst, input addr, input wdata,
    output rdata);
endinterface
`default_nettype wire

/* core/hb_bank.sv */
// One register bank covering a fixed slice of the 5-bit register address space.
`timescale 1ns/1ns
`default_nettype none
module hb_bank #(
  parameter logic [4:0] LO = hb_pkg::CH_LO,
  parameter logic [4:0] HI = hb_pkg::CH_HI
) (
  input wire logic i_ref_clk,
  hb_bank_if.bank bus
);
  import hb_pkg::*;

  typedef struct packed {
    logic [15:0] rdata;
  } hb_bank_st_t;

  hb_bank_st_t st;
  hb_bank_st_t next_st;
  logic [15:0] mem [CH_LO:CM_HI];
  logic hit;

  // Addresses outside this bank's slice neither store nor answer.
  assign hit = (bus.addr >= LO) && (bus.addr <= HI);

  always_comb begin
    next_st = st;
    // Unselected banks answer zero so the OR of all banks stays clean.
    next_st.rdata = (bus.rd && bus.sel && hit) ? mem[bus.addr] : 16'h0000;
  end

  always_ff @(posedge i_ref_clk) begin
    if (bus.srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (bus.srst) begin
      for (int i = LO; i <= HI; i++) begin
        mem[i] <= REG_RESET_VAL;
      end
    end else if (bus.we && bus.sel && hit) begin
      mem[bus.addr] <= bus.wdata;
    end
  end

  assign bus.rdata = st.rdata;
endmodule
`default_nettype wire

/* sim/hb_host_model.sv */
// Host side model: hard reset sequencing and resolution of the shared bus lines.
`timescale 1ns/1ns
`default_nettype none
module hb_host_model #(
  parameter int HOLD = 2000
) (
  input wire logic i_ref_clk,
  input wire logic i_hrst_req,
  input wire logic i_host_en,
  input wire logic [15:0] i_host_ad,
  input wire logic i_dev_oe,
  input wire logic [15:0] i_dev_ad,
  output logic [15:0] o_wire,
  output logic o_hard_rst_n
);
  logic [15:0] last = 16'h0000;
  // A released bus shows the inverse of its last level, so stale data cannot pass as a read.
  assign o_wire = i_host_en ? i_host_ad : (i_dev_oe ? i_dev_ad : ~last);
  always @(posedge i_ref_clk) begin
    last <= o_wire;
  end
  initial begin
    o_hard_rst_n = 1'b0;
    forever begin
      repeat (HOLD) @(posedge i_ref_clk);
      o_hard_rst_n <= 1'b1;
      @(posedge i_hrst_req);
      #3 o_hard_rst_n = 1'b0;
    end
  end
endmodule
`default_nettype wire

/* sim/hb_csr_port_tb_top.sv */
// Testbench for the multiplexed register port and its reset controls.
`timescale 1ns/1ns
`default_nettype none
module hb_csr_port_tb_top;
  import hb_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_cs_strobe = 1'b0;
  logic i_cs_rw = 1'b0;
  logic i_err_event = 1'b0;
  logic host_en = 1'b0;
  logic hrst_req = 1'b0;
  logic [15:0] host_ad = 16'h0000;
  logic [15:0] bus_w;
  logic [15:0] ad_out;
  logic oe, pll_rst, fifo_rst, soft_rst, err_l, hard_rst_n;
  int errors = 0;
  int total_checks = 0;
  int soft_n = 0;
  int fifo_n = 0;
  int s0;
  logic [15:0] wq[$];
  logic [15:0] rq[$];
  always #5 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) begin
    if (soft_rst === 1'b1) soft_n <= soft_n + 1;
    if (fifo_rst === 1'b1) fifo_n <= fifo_n + 1;
  end
  hb_host_model hb_host_model_inst (.i_ref_clk, .i_hrst_req(hrst_req), .i_host_en(host_en),
    .i_host_ad(host_ad), .i_dev_oe(oe), .i_dev_ad(ad_out), .o_wire(bus_w),
    .o_hard_rst_n(hard_rst_n));
  hb_csr_port hb_csr_port_inst (.i_ref_clk, .i_rst, .i_hard_rst_n(hard_rst_n), .i_cs_ad(bus_w),
    .i_cs_strobe, .i_cs_rw, .i_err_event, .o_cs_ad_out(ad_out), .o_cs_ad_oe(oe),
    .o_pll_rst(pll_rst), .o_fifo_rst(fifo_rst), .o_soft_rst(soft_rst), .o_err_latched(err_l));
  // ********************
  // Bus access tasks
  // ********************
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [15:0] aw(input logic b, input logic [4:0] en, input logic [4:0] sp,
      input logic [4:0] st);
    return {b, en, sp, st};
  endfunction
  // Writes every word of wq; strobe stays high until the last data cycle.
  task automatic wr(input logic [15:0] a);
    @(posedge i_ref_clk);
    host_en <= 1'b1;
    host_ad <= a;
    i_cs_strobe <= 1'b1;
    i_cs_rw <= 1'b0;
    foreach (wq[k]) begin
      @(posedge i_ref_clk);
      host_ad <= wq[k];
      i_cs_strobe <= (k < wq.size() - 1);
    end
    @(posedge i_ref_clk);
    host_en <= 1'b0;
    i_cs_strobe <= 1'b0;
  endtask
  // Collects every cycle in which the port drives the bus; the bus is idle afterwards.
  task automatic rd(input logic [15:0] a, input int n, input logic hold);
    int k;
    rq.delete();
    @(posedge i_ref_clk);
    host_en <= 1'b1;
    host_ad <= a;
    i_cs_strobe <= 1'b1;
    i_cs_rw <= 1'b1;
    for (k = 1; k < 40; k++) begin
      @(posedge i_ref_clk);
      host_en <= 1'b0;
      i_cs_strobe <= (k < n);
      i_cs_rw <= hold && k == 1;
      #1;
      if (oe === 1'b1) rq.push_back(bus_w);
      else if (rq.size() > 0) break;
    end
    @(posedge i_ref_clk);
    chk("read words", 16'(wq.size()), 16'(rq.size()));
    foreach (wq[i]) if (i < rq.size()) chk("read data", wq[i], rq[i]);
  endtask
  task automatic hwait();
    int k;
    k = 0;
    while (hard_rst_n !== 1'b1 && k < 3000) begin
      @(posedge i_ref_clk);
      #1;
      k++;
    end
    repeat (3) @(posedge i_ref_clk);
    // Let the synchroniser flops settle before anyone looks at the reset outputs.
    #1;
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    $display("Error watchdog expected done seen timeout");
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    #1;
    chk("pll_rst held", 16'h0001, 16'(pll_rst));
    chk("fifo_rst held", 16'h0001, 16'(fifo_rst));
    hwait();
    chk("pll_rst released", 16'h0000, 16'(pll_rst));
    s0 = fifo_n;
    wq = '{16'h0008};
    wr(aw(1'b0, 5'h10, 5'h00, REG_RESET_CTL));
    repeat (3) @(posedge i_ref_clk);
    chk("fifo pulse", 16'h0001, 16'(fifo_n - s0));
    wq = '{16'ha5c3};
    wr(aw(1'b0, 5'h05, 5'h1f, 5'h05));
    wq = '{16'h1818};
    wr(aw(1'b0, 5'h02, 5'h00, 5'h05));
    wq = '{16'ha5c3};
    rd(aw(1'b0, 5'h01, 5'h09, 5'h05), 1, 1'b0);
    rd(aw(1'b0, 5'h04, 5'h00, 5'h05), 1, 1'b0);
    wq = '{16'h0000};
    rd(aw(1'b0, 5'h08, 5'h00, 5'h05), 1, 1'b0);
    rd(aw(1'b0, 5'h00, 5'h00, 5'h06), 1, 1'b0);
    wq = '{16'hbddb};
    rd(aw(1'b0, 5'h0f, 5'h00, 5'h05), 1, 1'b0);
    wq = '{16'h7e7e};
    wr(aw(1'b0, 5'h1f, 5'h00, 5'h18));
    rd(aw(1'b0, 5'h10, 5'h00, 5'h18), 1, 1'b0);
    wq = '{16'h0000};
    rd(aw(1'b0, 5'h01, 5'h00, 5'h18), 1, 1'b0);
    wq = '{16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'h5555};
    wr(aw(1'b1, 5'h08, 5'h13, 5'h10));
    wq = '{16'h5555, 16'h2222, 16'h3333, 16'h4444, 16'h5555};
    // Strobe in the turnaround cycle does not count, so five words need it for cycles 1 to 5.
    rd(aw(1'b1, 5'h08, 5'h13, 5'h10), 6, 1'b0);
    wq = '{16'h2222, 16'h2222};
    rd(aw(1'b0, 5'h08, 5'h00, 5'h11), 1, 1'b1);
    wq = '{16'h5555, 16'h5555, 16'h2222, 16'h2222};
    rd(aw(1'b1, 5'h08, 5'h11, 5'h10), 5, 1'b1);
    wq = '{16'hffff};
    wr(aw(1'b0, 5'h10, 5'h00, REG_STATUS));
    wq = '{16'h0000};
    rd(aw(1'b0, 5'h10, 5'h00, REG_STATUS), 1, 1'b0);
    rd(aw(1'b0, 5'h10, 5'h00, REG_RESET_CTL), 1, 1'b0);
    @(posedge i_ref_clk);
    i_err_event <= 1'b1;
    @(posedge i_ref_clk);
    i_err_event <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    #1;
    chk("err latched", 16'h0001, 16'(err_l));
    wq = '{16'h0001};
    rd(aw(1'b0, 5'h10, 5'h00, REG_STATUS), 1, 1'b0);
    s0 = soft_n;
    wr(aw(1'b0, 5'h10, 5'h00, REG_RESET_CTL));
    repeat (3) @(posedge i_ref_clk);
    #1;
    chk("soft pulse", 16'h0001, 16'(soft_n - s0));
    chk("err kept", 16'h0001, 16'(err_l));
    wq = '{16'h0000};
    rd(aw(1'b0, 5'h01, 5'h00, 5'h05), 1, 1'b0);
    rd(aw(1'b0, 5'h10, 5'h00, 5'h18), 1, 1'b0);
    s0 = fifo_n;
    wq = '{16'h0008};
    wr(aw(1'b0, 5'h10, 5'h00, REG_RESET_CTL));
    repeat (3) @(posedge i_ref_clk);
    #1;
    chk("err cleared", 16'h0000, 16'(err_l));
    chk("fifo pulse", 16'h0001, 16'(fifo_n - s0));
    wq = '{16'h6c6c};
    wr(aw(1'b0, 5'h04, 5'h00, 5'h03));
    rd(aw(1'b0, 5'h04, 5'h00, 5'h03), 1, 1'b0);
    hrst_req <= 1'b1;
    repeat (5) @(posedge i_ref_clk);
    #1;
    chk("pll_rst again", 16'h0001, 16'(pll_rst));
    hrst_req <= 1'b0;
    hwait();
    wq = '{16'h0008};
    wr(aw(1'b0, 5'h10, 5'h00, REG_RESET_CTL));
    wq = '{16'h0000};
    rd(aw(1'b0, 5'h04, 5'h00, 5'h03), 1, 1'b0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
